//--- src/idm_regs.svh
// constants for the internal data memory map block
// assumes inclusion by the package and the map module
`ifndef IDM_REGS_SVH
`define IDM_REGS_SVH
`define IDM_DEPTH 256
`define IDM_HALF_BIT 7
`define IDM_BANK_BYTES 8
`define IDM_BANK_END 8'h1f
`define IDM_BIT_BASE 8'h20
`define IDM_BIT_END 8'h2f
`define IDM_AUX_DEPTH 512
`define IDM_STORE_DEPTH 16384
`define IDM_STORE_MAX_HZ 8000000
`define IDM_CORE_HZ 250000000
`define IDM_STORE_WAIT 6'h1f
`define IDM_AUX_WAIT 2'h2
`endif

//--- src/idm_pkg.sv
// types shared by the internal data memory map block
// assumes the constants header sits beside it
`include "idm_regs.svh"
package idm_pkg;
    typedef enum logic [1:0] {idm_acc_direct, idm_acc_indirect, idm_acc_bit, idm_acc_reg} idm_acc_e;
    typedef struct packed {
        logic valid;
        logic write;
        idm_acc_e kind;
        logic [7:0] addr;
        logic [7:0] wdata;
    } idm_req_s;
    typedef struct packed {
        logic valid;
        logic [7:0] rdata;
        logic sfr_sel;
    } idm_rsp_s;
    typedef enum logic [1:0] {idm_idle, idm_rmw, idm_wait} idm_state_e;
endpackage : idm_pkg

//--- src/idm_mem.sv
// single port byte memory with registered read data
// assumes one clock, async active low reset
`timescale 1ns/10ps
module idm_mem #(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata_ff
);
    logic [7:0] mem [DEPTH];
    // refuse a depth that the address cannot reach
    if (DEPTH > (1 << AW))
    begin : g_bad_depth
        $error("idm_mem depth too large for address");
    end
    // storage write
    always_ff @(posedge core_clk)
    begin
        if (we) mem[addr] <= wdata;
    end
    // registered read port
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst) rdata_ff <= 8'h00;
        else rdata_ff <= mem[addr];
    end
endmodule : idm_mem

//--- src/idm_map.sv
// internal data memory map: decode of direct, indirect, bit and working register access
// assumes a cpu core on core_clk holding each request until the answer valid pulse
`timescale 1ns/10ps
`include "idm_regs.svh"
module idm_map #(
    parameter int STORE_WAIT = `IDM_STORE_WAIT
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire idm_pkg::idm_req_s req,
    input wire logic bank_select_high,
    input wire logic bank_select_low,
    input wire logic [7:0] sfr_rdata,
    output idm_pkg::idm_rsp_s rsp_ff,
    output logic sfr_we_ff,
    output logic sfr_re_ff,
    output logic [7:0] sfr_addr_ff,
    output logic [7:0] sfr_wdata_ff,
    input wire logic aux_req,
    input wire logic aux_write,
    input wire logic [8:0] aux_addr,
    input wire logic [7:0] aux_wdata,
    output logic aux_done_ff,
    output logic [7:0] aux_rdata_ff,
    input wire logic fetch_req,
    input wire logic [13:0] fetch_addr,
    input wire logic [7:0] fetch_wdata,
    input wire logic fetch_write,
    output logic fetch_done_ff,
    output logic [7:0] fetch_rdata_ff
);
    import idm_pkg::*;
    localparam int STORE_MIN = `IDM_CORE_HZ / `IDM_STORE_MAX_HZ;
    // refuse a store wait that would fetch above the rate limit
    if (STORE_WAIT + 1 < STORE_MIN)
    begin : g_bad_wait
        $error("program store wait too short");
    end
    // ************************************************
    // request decode
    // ************************************************
    logic [7:0] phys;
    logic is_sfr;
    logic [2:0] bit_pos;
    logic [1:0] bank_idx;
    assign bank_idx = {bank_select_high, bank_select_low};
    assign bit_pos = req.addr[2:0];
    always_comb
    begin
        is_sfr = 1'b0;
        phys = req.addr;
        if (req.kind == idm_acc_reg)
        begin
            phys = {3'h0, bank_idx, req.addr[2:0]};
        end
        else if (req.kind == idm_acc_bit)
        begin
            if (req.addr[7]) is_sfr = 1'b1;
            else phys = `IDM_BIT_BASE | {4'h0, req.addr[6:3]};
        end
        else if (req.kind == idm_acc_direct && req.addr[`IDM_HALF_BIT])
        begin
            is_sfr = 1'b1;
        end
        else
        begin
            phys = req.addr;
        end
    end
    // ************************************************
    // sequencer: byte access one cycle, bit write is read then write
    // ************************************************
    idm_state_e state_ff;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic [7:0] rmw_mask;
    assign rmw_mask = 8'h01 << bit_pos;
    always_comb
    begin
        mem_we = 1'b0;
        mem_wdata = req.wdata;
        if (req.valid && !is_sfr && req.write && req.kind != idm_acc_bit && state_ff == idm_idle)
            mem_we = 1'b1;
        // byte writes landed in idle; only a ram bit write merges here
        else if (state_ff == idm_rmw && req.write && req.kind == idm_acc_bit && !is_sfr)
        begin
            mem_we = 1'b1;
            mem_wdata = req.wdata[0] ? (mem_rdata | rmw_mask)
                                     : (mem_rdata & ~rmw_mask);
        end
    end
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst) state_ff <= idm_idle;
        else
        begin
            case (state_ff)
                idm_idle: if (req.valid) state_ff <= idm_rmw; // sfr leaves idle too, taken once
                idm_rmw: state_ff <= idm_wait;
                default: state_ff <= req.valid ? idm_wait : idm_idle;
            endcase
        end
    end
    idm_mem #(.DEPTH(`IDM_DEPTH), .AW(8)) u_ram (
        .core_clk(core_clk),
        .nrst(nrst),
        .we(mem_we),
        .addr(phys),
        .wdata(mem_wdata),
        .rdata_ff(mem_rdata)
    );
    // ************************************************
    // sfr port and answer
    // ************************************************
    logic sfr_pend_ff;
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sfr_we_ff <= 1'b0;
            sfr_re_ff <= 1'b0;
            sfr_addr_ff <= 8'h00;
            sfr_wdata_ff <= 8'h00;
            sfr_pend_ff <= 1'b0;
        end
        else
        begin
            sfr_we_ff <= req.valid && is_sfr && req.write && state_ff == idm_idle;
            sfr_re_ff <= req.valid && is_sfr && !req.write && state_ff == idm_idle;
            sfr_addr_ff <= req.addr;
            sfr_wdata_ff <= req.wdata;
            sfr_pend_ff <= req.valid && is_sfr && state_ff == idm_idle;
        end
    end
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst) rsp_ff <= '0;
        else
        begin
            rsp_ff.valid <= (state_ff == idm_rmw) || sfr_pend_ff;
            rsp_ff.sfr_sel <= sfr_pend_ff;
            if (sfr_pend_ff) rsp_ff.rdata <= sfr_rdata;
            else if (req.kind == idm_acc_bit) rsp_ff.rdata <= {7'h00, mem_rdata[bit_pos]};
            else rsp_ff.rdata <= mem_rdata;
        end
    end
    // ************************************************
    // auxiliary ram with longer access period
    // ************************************************
    logic [1:0] aux_cnt_ff;
    logic [7:0] aux_q;
    idm_mem #(.DEPTH(`IDM_AUX_DEPTH), .AW(9)) u_aux (
        .core_clk(core_clk),
        .nrst(nrst),
        .we(aux_req && aux_write && aux_cnt_ff == 2'h0),
        .addr(aux_addr),
        .wdata(aux_wdata),
        .rdata_ff(aux_q)
    );
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            aux_cnt_ff <= 2'h0;
            aux_done_ff <= 1'b0;
            aux_rdata_ff <= 8'h00;
        end
        else
        begin
            aux_done_ff <= 1'b0;
            if (aux_req && !aux_done_ff)
            begin
                if (aux_cnt_ff == `IDM_AUX_WAIT)
                begin
                    aux_cnt_ff <= 2'h0;
                    aux_done_ff <= 1'b1;
                    aux_rdata_ff <= aux_q;
                end
                else aux_cnt_ff <= aux_cnt_ff + 2'h1;
            end
            else aux_cnt_ff <= 2'h0;
        end
    end
    // ************************************************
    // program store, paced to its rate limit
    // ************************************************
    logic [5:0] st_cnt_ff;
    logic [7:0] st_q;
    idm_mem #(.DEPTH(`IDM_STORE_DEPTH), .AW(14)) u_store (
        .core_clk(core_clk),
        .nrst(nrst),
        .we(fetch_req && fetch_write && st_cnt_ff == 6'h00),
        .addr(fetch_addr),
        .wdata(fetch_wdata),
        .rdata_ff(st_q)
    );
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_cnt_ff <= 6'h00;
            fetch_done_ff <= 1'b0;
            fetch_rdata_ff <= 8'h00;
        end
        else
        begin
            fetch_done_ff <= 1'b0;
            if (fetch_req && !fetch_done_ff)
            begin
                if (st_cnt_ff == 6'(STORE_WAIT))
                begin
                    st_cnt_ff <= 6'h00;
                    fetch_done_ff <= 1'b1;
                    fetch_rdata_ff <= st_q;
                end
                else st_cnt_ff <= st_cnt_ff + 6'h01;
            end
            else st_cnt_ff <= 6'h00;
        end
    end
    // ************************************************
    // checks
    // ************************************************
    sequence req_start;
        req.valid && state_ff == idm_idle && !is_sfr;
    endsequence
    ram_answer_a: assert property (@(posedge core_clk) disable iff (!nrst)
        req_start |-> ##2 rsp_ff.valid && !rsp_ff.sfr_sel) else $error("ram answer late");
    sfr_answer_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (req.valid && is_sfr && state_ff == idm_idle) |-> ##1 sfr_pend_ff ##1 rsp_ff.sfr_sel)
        else $error("sfr answer missing");
    bank_map_a: assert property (@(posedge core_clk) disable iff (!nrst)
        req.kind == idm_acc_reg |-> phys[7:5] == 3'h0 && phys[4:3] == bank_idx)
        else $error("bank mapping wrong");
    bit_range_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (req.kind == idm_acc_bit && !req.addr[7]) |-> phys >= `IDM_BIT_BASE && phys <= `IDM_BIT_END)
        else $error("bit byte out of range");
    bit_keep_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_ff == idm_rmw && req.write && req.kind == idm_acc_bit && !is_sfr) |->
        mem_we && ((mem_wdata ^ mem_rdata) & ~rmw_mask) == 8'h00 &&
        (mem_wdata & rmw_mask) == (req.wdata[0] ? rmw_mask : 8'h00))
        else $error("bit write touched other bits");
    bit_addr_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (req.kind == idm_acc_bit && !req.addr[7]) |-> {phys[3:0], bit_pos} == req.addr[6:0])
        else $error("bit address map wrong");
    aux_slow_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(aux_req) |-> !aux_done_ff [*3]) else $error("aux ram too fast");
    store_pace_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(fetch_req) |-> !fetch_done_ff [*8]) else $error("store fetch too fast");
    sfr_apart_a: assert property (@(posedge core_clk) disable iff (!nrst)
        sfr_we_ff |-> !$past(mem_we)) else $error("sfr write hit ram");
endmodule : idm_map

//--- verif/idm_sfr_model.sv
// sfr space model on the direct upper half port of the map block
// assumes registered strobes from the map block on core_clk
`timescale 1ns/10ps
module idm_sfr_model (
    input wire logic core_clk,
    input wire logic sfr_we_ff,
    input wire logic sfr_re_ff,
    input wire logic [7:0] sfr_addr_ff,
    input wire logic [7:0] sfr_wdata_ff,
    output logic [7:0] sfr_rdata
);
    // ****************
    // storage kept apart from the ram
    // ****************
    logic [7:0] regs [0:255];
    logic [7:0] junk_ff = 8'h5a;
    // write strobe stores, idle cycles scramble the read bus
    always_ff @(posedge core_clk)
    begin
        junk_ff <= ~junk_ff ^ 8'h33;
        if (sfr_we_ff)
            regs[sfr_addr_ff] <= sfr_wdata_ff;
    end
    // read data only stands while the read strobe does
    assign sfr_rdata = sfr_re_ff ? regs[sfr_addr_ff] : junk_ff;
endmodule : idm_sfr_model

//--- verif/internal_data_memory_map_tb_top.sv
// self-checking bench for the internal data memory map
// assumes the sfr model file and the design package are compiled first
`timescale 1ns/10ps
module internal_data_memory_map_tb_top;
    import idm_pkg::*;
    localparam int SW = 30; // shortest program store wait allowed
    logic core_clk, nrst, bank_select_high, bank_select_low, sfr_we_ff, sfr_re_ff;
    logic aux_req, aux_write, aux_done_ff, fetch_req, fetch_write, fetch_done_ff;
    logic [7:0] sfr_rdata, sfr_addr_ff, sfr_wdata_ff, aux_wdata, aux_rdata_ff;
    logic [7:0] fetch_wdata, fetch_rdata_ff;
    logic [8:0] aux_addr;
    logic [13:0] fetch_addr;
    idm_req_s req;
    idm_rsp_s rsp_ff;
    logic [7:0] mem [0:255];
    logic [7:0] sfr [0:255];
    int num_errors = 0;
    int compares = 0;
    // ****************
    // design and far side
    // ****************
    idm_map #(.STORE_WAIT(SW)) u_dut (.core_clk(core_clk), .nrst(nrst), .req(req),
        .bank_select_high(bank_select_high), .bank_select_low(bank_select_low),
        .sfr_rdata(sfr_rdata), .rsp_ff(rsp_ff), .sfr_we_ff(sfr_we_ff), .sfr_re_ff(sfr_re_ff),
        .sfr_addr_ff(sfr_addr_ff), .sfr_wdata_ff(sfr_wdata_ff), .aux_req(aux_req),
        .aux_write(aux_write), .aux_addr(aux_addr), .aux_wdata(aux_wdata),
        .aux_done_ff(aux_done_ff), .aux_rdata_ff(aux_rdata_ff), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .fetch_wdata(fetch_wdata), .fetch_write(fetch_write),
        .fetch_done_ff(fetch_done_ff), .fetch_rdata_ff(fetch_rdata_ff));
    idm_sfr_model u_sfr (.core_clk(core_clk), .sfr_we_ff(sfr_we_ff), .sfr_re_ff(sfr_re_ff),
        .sfr_addr_ff(sfr_addr_ff), .sfr_wdata_ff(sfr_wdata_ff), .sfr_rdata(sfr_rdata));
    // ****************
    // tasks
    // ****************
    // verdict and end of run
    task automatic close_out;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out
    // one comparison, counted
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // one internal access, request held until the answer pulse
    task automatic acc(input bit w, input idm_acc_e k, input int a, input logic [7:0] d,
        output logic [7:0] q);
        int n;
        req = '{valid: 1'b1, write: w, kind: k, addr: a[7:0], wdata: d};
        n = 0;
        do
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        while (rsp_ff.valid !== 1'b1 && n < 100);
        if (n >= 100)
        begin
            num_errors++;
            close_out();
        end
        q = rsp_ff.rdata;
        check("latency", 16'(n), 16'd2);
        check("sfr_sel", 16'(rsp_ff.sfr_sel), 16'((k != idm_acc_indirect) && a >= 128));
        req.valid = 1'b0;
        @(posedge core_clk);
        #1;
    endtask : acc
    // one aux ram or program store access with its wait counted
    task automatic side(input bit f, input bit w, input int a, input logic [7:0] d,
        output logic [7:0] q);
        int n;
        if (f)
            {fetch_write, fetch_addr, fetch_wdata, fetch_req} = {w, a[13:0], d, 1'b1};
        else
            {aux_write, aux_addr, aux_wdata, aux_req} = {w, a[8:0], d, 1'b1};
        n = 0;
        do
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        while ((f ? fetch_done_ff : aux_done_ff) !== 1'b1 && n < 100);
        if (n >= 100)
        begin
            num_errors++;
            close_out();
        end
        q = f ? fetch_rdata_ff : aux_rdata_ff;
        check(f ? "store_wait" : "aux_wait", 16'(n), f ? 16'(SW + 1) : 16'd3);
        fetch_req = 1'b0;
        aux_req = 1'b0;
        @(posedge core_clk);
        #1;
    endtask : side
    // ****************
    // clock and scenarios
    // ****************
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial
    begin : main
        int a, b, n, y;
        logic [7:0] d, q;
        {nrst, bank_select_high, bank_select_low, aux_req, fetch_req} = '0;
        {aux_write, aux_addr, aux_wdata, fetch_write, fetch_addr, fetch_wdata} = '0;
        req = '0;
        void'($urandom(60282));
        repeat (4) @(posedge core_clk);
        #1;
        check("rst_rsp", 16'(rsp_ff.valid), 16'd0);
        nrst = 1'b1;
        // low half: direct and indirect reach the same bytes
        for (n = 0; n < 8; n++)
        begin
            a = $urandom_range(127);
            d = $urandom;
            acc(1, n[0] ? idm_acc_direct : idm_acc_indirect, a, d, q);
            mem[a] = d;
            acc(0, n[0] ? idm_acc_indirect : idm_acc_direct, a, 0, q);
            check("low", q, mem[a]);
        end
        // upper half: indirect ram and direct sfr stay apart
        for (n = 0; n < 4; n++)
        begin
            a = 128 + $urandom_range(127);
            d = $urandom;
            acc(1, idm_acc_indirect, a, d, q);
            mem[a] = d;
            acc(1, idm_acc_direct, a, ~d, q);
            sfr[a] = ~d;
            acc(0, idm_acc_indirect, a, 0, q);
            check("ram_hi", q, mem[a]);
            acc(0, idm_acc_direct, a, 0, q);
            check("sfr_hi", q, sfr[a]);
            // bit access above 0x7f goes to the sfr port unchanged, ram untouched
            d = $urandom;
            acc(1, idm_acc_bit, a, d, q);
            sfr[a] = d;
            acc(0, idm_acc_direct, a, 0, q);
            check("sfr_bit", q, sfr[a]);
            acc(0, idm_acc_indirect, a, 0, q);
            check("ram_keep", q, mem[a]);
        end
        // working registers first and last in every bank
        for (b = 0; b < 4; b++)
        begin
            {bank_select_high, bank_select_low} = b[1:0];
            for (n = 0; n < 8; n += 7)
            begin
                d = $urandom;
                acc(1, idm_acc_reg, n, d, q);
                mem[b * 8 + n] = d;
                acc(0, idm_acc_direct, b * 8 + n, 0, q);
                check("bank", q, mem[b * 8 + n]);
                acc(0, idm_acc_reg, n, 0, q);
                check("reg", q, mem[b * 8 + n]);
            end
        end
        // bit region: preload, then single bit writes and reads
        for (a = 32; a < 48; a++)
        begin
            d = $urandom;
            acc(1, idm_acc_direct, a, d, q);
            mem[a] = d;
        end
        for (n = 0; n < 12; n++)
        begin
            a = (n == 0) ? 0 : (n == 1) ? 127 : $urandom_range(127);
            y = 32 + a / 8;
            d = $urandom;
            acc(1, idm_acc_bit, a, d, q);
            mem[y][a % 8] = d[0];
            acc(0, idm_acc_bit, a, 0, q);
            check("bit", 16'(q), 16'(mem[y][a % 8]));
            acc(0, idm_acc_direct, y, 0, q);
            check("bit_byte", q, mem[y]);
        end
        // aux ram top address and random addresses, and program store
        for (n = 0; n < 4; n++)
        begin
            a = n[0] ? 511 : $urandom_range(510);
            d = $urandom;
            side(0, 1, a, d, q);
            side(0, 0, a, 0, q);
            check("aux", q, d);
        end
        a = $urandom_range(16383);
        d = $urandom;
        side(1, 1, a, d, q);
        side(1, 0, a, 0, q);
        check("store", q, d);
        close_out();
    end
endmodule : internal_data_memory_map_tb_top
